// >>> irqpap_pkg.sv
// constants and carrier types of the pending, active and priority block
package irqpap_pkg;

   // ****************************************************
   // geometry
   // ****************************************************
   localparam int NUM_IRQ   = 64;
   localparam int ADDR_W    = 12;
   localparam int DATA_W    = 32;
   localparam int STRB_W    = 4;
   localparam int PRIO_W    = 4;
   localparam int PRIO_WRDS = 16;
   localparam int EVT_W     = 2;

   // ****************************************************
   // register offsets (byte addresses from irq_ctrl_base)
   // ****************************************************
   localparam logic [11:0] OFS_PEND_SET_LO = 12'h100;
   localparam logic [11:0] OFS_PEND_SET_HI = 12'h104;
   localparam logic [11:0] OFS_PEND_CLR_LO = 12'h180;
   localparam logic [11:0] OFS_PEND_CLR_HI = 12'h184;
   localparam logic [11:0] OFS_ACT_LO      = 12'h200;
   localparam logic [11:0] OFS_ACT_HI      = 12'h204;
   localparam logic [11:0] OFS_PRIO_FIRST  = 12'h300;
   localparam logic [11:0] OFS_PRIO_LAST   = 12'h33c;
   localparam logic [11:0] OFS_EVT_STAT    = 12'h400;
   localparam logic [11:0] OFS_EVT_MASK    = 12'h404;

   // ****************************************************
   // fields and reset values
   // ****************************************************
   localparam logic [31:0] PRIO_MASK = 32'hf0f0f0f0;
   localparam int PRIO_LANE0_LSB = 4;
   localparam int PRIO_LANE_STEP = 8;
   localparam int EVT_PEND_BIT   = 0;
   localparam int EVT_ACT_BIT    = 1;
   localparam logic [31:0] RST_WORD = 32'h00000000;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] data;
      logic [3:0]  strb;
   } irqpap_wr_t;

   typedef struct packed {
      logic [31:0] data;
      logic [1:0]  resp;
   } irqpap_rd_t;

endpackage

// >>> irqpap_top.sv
// pending clear, active flags and priority registers over axi4-lite
`timescale 1ns/10ps

// Contract
// - writing one to a pending-clear bit removes that line's pending state
// - writing zero to a pending-clear bit leaves that line unchanged
// - reading pending-clear word returns the current pending status
// - active-flag words show one bit per line, one when active
// - each line holds four-bit priority, zero most urgent, fifteen least
// - priority word packs lines 4n..4n+3 at bits 7:4,15:12,23:20,31:28
// - pending-clear, active and priority words read zero after reset
// - active flags for 64 lines sit at offsets 0x200 and 0x204
// - writing one to a pending-set bit makes that line pending
module irqpap_top
   import irqpap_pkg::*;
(
   input  wire logic               aclk,
   input  wire logic               aresetn,
   input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic [2:0]         s_axi_awprot,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [DATA_W-1:0]  s_axi_wdata,
   input  wire logic [STRB_W-1:0]  s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire logic [ADDR_W-1:0]  s_axi_araddr,
   input  wire logic [2:0]         s_axi_arprot,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [DATA_W-1:0]       s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   input  wire logic [NUM_IRQ-1:0] irq_line_req,
   input  wire logic [NUM_IRQ-1:0] active_set,
   input  wire logic [NUM_IRQ-1:0] active_clr,
   output logic [NUM_IRQ-1:0]      pending_o,
   output logic [NUM_IRQ-1:0]      active_o,
   output logic [NUM_IRQ*PRIO_W-1:0] prio_o,
   output logic                    irq_o
);

   // ****************************************************
   // helpers
   // ****************************************************
   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      logic m;
      m = (a == OFS_PEND_SET_LO) || (a == OFS_PEND_SET_HI) ||
          (a == OFS_PEND_CLR_LO) || (a == OFS_PEND_CLR_HI) ||
          (a == OFS_ACT_LO)      || (a == OFS_ACT_HI)      ||
          (a == OFS_EVT_STAT)    || (a == OFS_EVT_MASK)    ||
          ((a >= OFS_PRIO_FIRST) && (a <= OFS_PRIO_LAST) &&
           (a[1:0] == 2'h0));
      return m;
   endfunction

   function automatic logic [DATA_W-1:0] strb_mask(
      input logic [STRB_W-1:0] s);
      logic [DATA_W-1:0] m;
      m = '0;
      for (int b = 0; b < STRB_W; b++) begin
         m[b*8 +: 8] = {8{s[b]}};
      end
      return m;
   endfunction

   // ****************************************************
   // state
   // ****************************************************
   logic                   aw_held_q, aw_held_d;
   logic                   w_held_q, w_held_d;
   irqpap_wr_t             wr_q, wr_d;
   logic                   awready_q, awready_d;
   logic                   wready_q, wready_d;
   logic                   bvalid_q, bvalid_d;
   logic [1:0]             bresp_q, bresp_d;
   logic                   arready_q, arready_d;
   logic                   rvalid_q, rvalid_d;
   irqpap_rd_t             rd_q, rd_d;

   logic [NUM_IRQ-1:0]     pend_q, pend_d;
   logic [NUM_IRQ-1:0]     act_q, act_d;
   logic [DATA_W-1:0]      prio_q [PRIO_WRDS];
   logic [DATA_W-1:0]      prio_d [PRIO_WRDS];
   logic [EVT_W-1:0]       stat_q, stat_d;
   logic [EVT_W-1:0]       mask_q, mask_d;
   logic                   irq_q, irq_d;

   logic                   do_wr;
   logic [DATA_W-1:0]      wmask;
   logic [DATA_W-1:0]      wbits;
   logic [NUM_IRQ-1:0]     sw_set;
   logic [NUM_IRQ-1:0]     sw_clr;
   logic [EVT_W-1:0]       stat_w1c;
   logic [EVT_W-1:0]       evt;
   logic [3:0]             prio_idx;

   // ****************************************************
   // write channel
   // ****************************************************
   // address and data are taken independently, in any order;
   // the write is applied once both are held and no response waits
   assign do_wr = aw_held_q && w_held_q && !bvalid_q;

   always_comb begin
      aw_held_d = aw_held_q;
      w_held_d  = w_held_q;
      wr_d      = wr_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      if (s_axi_awvalid && awready_q) begin
         aw_held_d   = 1'b1;
         wr_d.addr   = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q) begin
         w_held_d    = 1'b1;
         wr_d.data   = s_axi_wdata;
         wr_d.strb   = s_axi_wstrb;
      end
      if (do_wr) begin
         aw_held_d = 1'b0;
         w_held_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = is_mapped(wr_q.addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_d  = 1'b0;
      end
      // readies are flops, so look one cycle ahead
      awready_d = !aw_held_d && !bvalid_d;
      wready_d  = !w_held_d && !bvalid_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         wr_q      <= '0;
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end else begin
         aw_held_q <= aw_held_d;
         w_held_q  <= w_held_d;
         wr_q      <= wr_d;
         awready_q <= awready_d;
         wready_q  <= wready_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
      end
   end

   // ****************************************************
   // write decode
   // ****************************************************
   assign wmask    = strb_mask(wr_q.strb);
   assign wbits    = wr_q.data & wmask;
   assign prio_idx = wr_q.addr[5:2];

   always_comb begin
      sw_set   = '0;
      sw_clr   = '0;
      stat_w1c = '0;
      mask_d   = mask_q;
      for (int i = 0; i < PRIO_WRDS; i++) begin
         prio_d[i] = prio_q[i];
      end
      if (do_wr) begin
         unique case (wr_q.addr)
            OFS_PEND_SET_LO: begin
               sw_set[31:0] = wbits;
            end
            OFS_PEND_SET_HI: begin
               sw_set[63:32] = wbits;
            end
            OFS_PEND_CLR_LO: begin
               sw_clr[31:0] = wbits;
            end
            OFS_PEND_CLR_HI: begin
               sw_clr[63:32] = wbits;
            end
            OFS_EVT_STAT: begin
               stat_w1c = wbits[EVT_W-1:0];
            end
            OFS_EVT_MASK: begin
               mask_d = (mask_q & ~wmask[EVT_W-1:0]) |
                        wbits[EVT_W-1:0];
            end
            default: begin
               // active words are driven by the core only
               if (is_mapped(wr_q.addr) &&
                   (wr_q.addr >= OFS_PRIO_FIRST)) begin
                  prio_d[prio_idx] = ((prio_q[prio_idx] & ~wmask) |
                                      wbits) & PRIO_MASK;
               end
            end
         endcase
      end
   end

   // ****************************************************
   // pending, active, events
   // ****************************************************
   always_comb begin
      // a set in the same cycle as a clear wins
      pend_d = (pend_q & ~sw_clr) | sw_set | irq_line_req;
      act_d  = (act_q & ~active_clr) | active_set;
      evt[EVT_PEND_BIT] = |(pend_d & ~pend_q);
      evt[EVT_ACT_BIT]  = |(act_d & ~act_q);
      stat_d = (stat_q & ~stat_w1c) | evt;
      irq_d  = |(stat_d & mask_d);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_q <= '0;
         act_q  <= '0;
         stat_q <= '0;
         mask_q <= '0;
         irq_q  <= 1'b0;
         for (int i = 0; i < PRIO_WRDS; i++) begin
            prio_q[i] <= RST_WORD;
         end
      end else begin
         pend_q <= pend_d;
         act_q  <= act_d;
         stat_q <= stat_d;
         mask_q <= mask_d;
         irq_q  <= irq_d;
         for (int i = 0; i < PRIO_WRDS; i++) begin
            prio_q[i] <= prio_d[i];
         end
      end
   end

   // ****************************************************
   // read channel
   // ****************************************************
   always_comb begin
      // idle with no answer waiting means ready, also just after reset
      arready_d = arready_q || !rvalid_q;
      rvalid_d  = rvalid_q;
      rd_d      = rd_q;
      if (s_axi_arvalid && arready_q) begin
         arready_d = 1'b0;
         rvalid_d  = 1'b1;
         rd_d.data = '0;
         rd_d.resp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         unique case (s_axi_araddr)
            OFS_PEND_SET_LO, OFS_PEND_CLR_LO: begin
               rd_d.data = pend_q[31:0];
            end
            OFS_PEND_SET_HI, OFS_PEND_CLR_HI: begin
               rd_d.data = pend_q[63:32];
            end
            OFS_ACT_LO: begin
               rd_d.data = act_q[31:0];
            end
            OFS_ACT_HI: begin
               rd_d.data = act_q[63:32];
            end
            OFS_EVT_STAT: begin
               rd_d.data[EVT_W-1:0] = stat_q;
            end
            OFS_EVT_MASK: begin
               rd_d.data[EVT_W-1:0] = mask_q;
            end
            default: begin
               if (is_mapped(s_axi_araddr) &&
                   (s_axi_araddr >= OFS_PRIO_FIRST)) begin
                  rd_d.data = prio_q[s_axi_araddr[5:2]];
               end
            end
         endcase
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d  = 1'b0;
         arready_d = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rd_q      <= '0;
      end else begin
         arready_q <= arready_d;
         rvalid_q  <= rvalid_d;
         rd_q      <= rd_d;
      end
   end

   // ****************************************************
   // outputs
   // ****************************************************
   // one nibble per line, zero most urgent
   always_comb begin
      for (int i = 0; i < NUM_IRQ; i++) begin
         prio_o[i*PRIO_W +: PRIO_W] =
            prio_q[i/4][PRIO_LANE0_LSB + PRIO_LANE_STEP*(i%4) +: PRIO_W];
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rd_q.data;
   assign s_axi_rresp   = rd_q.resp;
   assign pending_o     = pend_q;
   assign active_o      = act_q;
   assign irq_o         = irq_q;

endmodule // irqpap_top

// >>> irqpap_checker.sv
// port assertions for the pending, active and priority block
`timescale 1ns/10ps
module irqpap_checker
   import irqpap_pkg::*;
(
   input wire logic         aclk,
   input wire logic         aresetn,
   input wire logic [11:0]  s_axi_awaddr,
   input wire logic         s_axi_awvalid,
   input wire logic [31:0]  s_axi_wdata,
   input wire logic         s_axi_wvalid,
   input wire logic         s_axi_bvalid,
   input wire logic [11:0]  s_axi_araddr,
   input wire logic         s_axi_arvalid,
   input wire logic [31:0]  s_axi_rdata,
   input wire logic         s_axi_rvalid,
   input wire logic [63:0]  irq_line_req,
   input wire logic [63:0]  pending_o,
   input wire logic [63:0]  active_o,
   input wire logic [255:0] prio_o
);
   // valid is held until taken, so the last value seen is the request
   logic [11:0] aw_q;
   logic [11:0] ar_q;
   logic [31:0] wd_q;
   logic [31:0] prio_lo;
   assign prio_lo = {prio_o[15:12], 4'h0, prio_o[11:8], 4'h0,
                     prio_o[7:4], 4'h0, prio_o[3:0], 4'h0};
   always_ff @(posedge aclk) begin
      if (s_axi_awvalid) aw_q <= s_axi_awaddr;
      if (s_axi_wvalid) wd_q <= s_axi_wdata;
      if (s_axi_arvalid) ar_q <= s_axi_araddr;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // the bench always writes full strobes
   chk_pend_clear: assert property ($rose(s_axi_bvalid) &&
      aw_q == OFS_PEND_CLR_HI |-> (pending_o[63:32] & wd_q &
      ~$past(irq_line_req[63:32])) == 32'h0) else $error("clear missed");
   chk_pend_keep: assert property ($rose(s_axi_bvalid) &&
      aw_q == OFS_PEND_CLR_HI |-> (pending_o[63:32] & ~wd_q) ==
      (($past(pending_o[63:32]) | $past(irq_line_req[63:32])) & ~wd_q))
      else $error("zero bit changed pending");
   chk_pend_set: assert property ($rose(s_axi_bvalid) &&
      aw_q == OFS_PEND_SET_HI |-> pending_o[63:32] == ($past(
      pending_o[63:32]) | wd_q | $past(irq_line_req[63:32])))
      else $error("set missed");
   chk_pend_read: assert property ($rose(s_axi_rvalid) &&
      ar_q == OFS_PEND_CLR_HI && $stable(pending_o) |->
      s_axi_rdata == pending_o[63:32]) else $error("pending read wrong");
   chk_act_lo: assert property ($rose(s_axi_rvalid) &&
      ar_q == OFS_ACT_LO && $stable(active_o) |->
      s_axi_rdata == active_o[31:0]) else $error("active lo wrong");
   chk_act_hi: assert property ($rose(s_axi_rvalid) &&
      ar_q == OFS_ACT_HI && $stable(active_o) |->
      s_axi_rdata == active_o[63:32]) else $error("active hi wrong");
   chk_prio_lanes: assert property ($rose(s_axi_rvalid) &&
      ar_q == OFS_PRIO_FIRST && $stable(prio_o) |->
      s_axi_rdata == prio_lo) else $error("priority read wrong");
   chk_reset_zero: assert property ($rose(aresetn) |->
      pending_o == 64'h0 && active_o == 64'h0 && prio_o == 256'h0)
      else $error("state not zero after reset");
   cover property ($rose(s_axi_bvalid) && aw_q == OFS_PEND_CLR_HI);
   cover property ($rose(s_axi_rvalid) && ar_q == OFS_ACT_HI);
   cover property ($rose(s_axi_rvalid) && ar_q == OFS_PRIO_FIRST);
endmodule // irqpap_checker

bind irqpap_top irqpap_checker u_chk (
   .aclk          (aclk),
   .aresetn       (aresetn),
   .s_axi_awaddr  (s_axi_awaddr),
   .s_axi_awvalid (s_axi_awvalid),
   .s_axi_wdata   (s_axi_wdata),
   .s_axi_wvalid  (s_axi_wvalid),
   .s_axi_bvalid  (s_axi_bvalid),
   .s_axi_araddr  (s_axi_araddr),
   .s_axi_arvalid (s_axi_arvalid),
   .s_axi_rdata   (s_axi_rdata),
   .s_axi_rvalid  (s_axi_rvalid),
   .irq_line_req  (irq_line_req),
   .pending_o     (pending_o),
   .active_o      (active_o),
   .prio_o        (prio_o)
);

// >>> irqpap_core_model.sv
// core-side model driving line requests and active marks
`timescale 1ns/10ps
module irqpap_core_model
   import irqpap_pkg::*;
(
   input  wire logic          aclk,
   output logic [NUM_IRQ-1:0] irq_line_req = '0,
   output logic [NUM_IRQ-1:0] active_set   = '0,
   output logic [NUM_IRQ-1:0] active_clr   = '0
);
   // kind 0 raises a request, 1 enters a handler, 2 leaves it;
   // one cycle only, since a held request keeps re-setting pending
   task automatic pulse(input int kind, input int n);
      logic [NUM_IRQ-1:0] v;
      v = '0;
      v[n] = 1'b1;
      @(posedge aclk);
      case (kind)
         0: irq_line_req <= v;
         1: active_set <= v;
         default: active_clr <= v;
      endcase
      @(posedge aclk);
      irq_line_req <= '0;
      active_set <= '0;
      active_clr <= '0;
   endtask
endmodule // irqpap_core_model

// >>> irqpap_tb_top.sv
// self-checking bench for the pending, active and priority block
`timescale 1ns/10ps
module irqpap_tb_top
   import irqpap_pkg::*;
;
   logic         aclk          = 1'b0;
   logic         aresetn       = 1'b0;
   logic [11:0]  s_axi_awaddr  = 12'h0;
   logic [11:0]  s_axi_araddr  = 12'h0;
   logic [2:0]   s_axi_awprot  = 3'h0;
   logic [2:0]   s_axi_arprot  = 3'h0;
   logic [31:0]  s_axi_wdata   = 32'h0;
   logic [3:0]   s_axi_wstrb   = 4'h0;
   logic         s_axi_awvalid = 1'b0;
   logic         s_axi_wvalid  = 1'b0;
   logic         s_axi_bready  = 1'b0;
   logic         s_axi_arvalid = 1'b0;
   logic         s_axi_rready  = 1'b0;
   logic         s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic         s_axi_arready, s_axi_rvalid, irq_o;
   logic [1:0]   s_axi_bresp, s_axi_rresp, rs;
   logic [31:0]  s_axi_rdata, rd;
   logic [63:0]  irq_line_req, active_set, active_clr;
   logic [63:0]  pending_o, active_o;
   logic [255:0] prio_o;
   int           fail_count = 0;
   int           n_checks   = 0;
   logic [11:0]  rst_tab [6] = '{OFS_PEND_CLR_LO, OFS_PEND_CLR_HI,
      OFS_ACT_LO, OFS_ACT_HI, OFS_PRIO_FIRST, OFS_PRIO_LAST};

   always #4 aclk = ~aclk;
   irqpap_top u_dut (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awprot  (s_axi_awprot),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arprot  (s_axi_arprot),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .irq_line_req  (irq_line_req),
      .active_set    (active_set),
      .active_clr    (active_clr),
      .pending_o     (pending_o),
      .active_o      (active_o),
      .prio_o        (prio_o),
      .irq_o         (irq_o)
   );
   irqpap_core_model u_core (
      .aclk         (aclk),
      .irq_line_req (irq_line_req),
      .active_set   (active_set),
      .active_clr   (active_clr)
   );

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd_word(input logic [11:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      rd_word(a);
      chk(rd, exp);
   endtask
   task automatic do_reset();
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
   endtask
   task automatic conclude();
      $display("checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      do_reset();
      foreach (rst_tab[i]) rchk(rst_tab[i], RST_WORD);
      $display("test reset values done");
      wr(OFS_PEND_SET_HI, 32'h80000001);
      rchk(OFS_PEND_CLR_HI, 32'h80000001);
      wr(OFS_PEND_CLR_HI, 32'h00000001);
      rchk(OFS_PEND_CLR_HI, 32'h80000000);
      u_core.pulse(0, 40);
      rchk(OFS_PEND_CLR_HI, 32'h80000100);
      wr(OFS_PEND_SET_LO, 32'h00000010);
      rchk(OFS_PEND_CLR_LO, 32'h00000010);
      wr(OFS_PEND_CLR_HI, 32'hffffffff);
      rchk(OFS_PEND_CLR_HI, 32'h00000000);
      $display("test pending done");
      u_core.pulse(1, 5);
      u_core.pulse(1, 63);
      rchk(OFS_ACT_LO, 32'h00000020);
      rchk(OFS_ACT_HI, 32'h80000000);
      wr(OFS_ACT_LO, 32'hffffffff);
      chk({30'h0, rs}, {30'h0, RESP_OKAY});
      rchk(OFS_ACT_LO, 32'h00000020);
      u_core.pulse(2, 5);
      rchk(OFS_ACT_LO, 32'h00000000);
      $display("test active done");
      wr(OFS_PRIO_FIRST, 32'hffffffff);
      rchk(OFS_PRIO_FIRST, PRIO_MASK);
      chk({28'h0, prio_o[3:0]}, 32'h0000000f);
      wr(OFS_PRIO_LAST, 32'h12345678);
      rchk(OFS_PRIO_LAST, 32'h10305070);
      chk(prio_o[255:224], 32'h13570000);
      $display("test priority done");
      wr(12'h800, 32'hffffffff);
      chk({30'h0, rs}, {30'h0, RESP_SLVERR});
      rchk(12'h800, 32'h00000000);
      chk({30'h0, rs}, {30'h0, RESP_SLVERR});
      $display("test unmapped done");
      wr(OFS_EVT_STAT, 32'h00000003);
      wr(OFS_EVT_MASK, 32'h00000000);
      u_core.pulse(0, 2);
      rchk(OFS_EVT_STAT, 32'h00000001);
      chk({31'h0, irq_o}, 32'h00000000);
      wr(OFS_EVT_MASK, 32'h00000001);
      rchk(OFS_EVT_MASK, 32'h00000001);
      chk({31'h0, irq_o}, 32'h00000001);
      wr(OFS_EVT_STAT, 32'h00000001);
      rchk(OFS_EVT_STAT, 32'h00000000);
      chk({31'h0, irq_o}, 32'h00000000);
      u_core.pulse(1, 7);
      rchk(OFS_ACT_LO, 32'h00000080);
      rchk(OFS_EVT_STAT, 32'h00000002);
      chk({31'h0, irq_o}, 32'h00000000);
      $display("test interrupt done");
      do_reset();
      rchk(OFS_PEND_CLR_LO, RST_WORD);
      rchk(OFS_PRIO_LAST, RST_WORD);
      rchk(OFS_ACT_HI, RST_WORD);
      $display("test second reset done");
      conclude();
   end

   // a hung handshake would otherwise stall the run forever
   initial begin
      repeat (5000) @(posedge aclk);
      fail_count++;
      conclude();
   end
endmodule // irqpap_tb_top
